// *** common/float_seq_pkg.sv ***
`include "float_seq_regs.svh"

package float_seq_pkg;

  // sequencer states, gray coded along idle-run-drain-write
  typedef enum logic [1:0]
  {
    IDLE_S  = 2'b00,
    RUN_S   = 2'b01,
    DRAIN_S = 2'b11,
    WRITE_S = 2'b10
  } seq_state_type;

  typedef logic [`NUM_REGS-1:0][15:0] reg_bank_type;

  typedef struct packed
  {
    seq_state_type            fsm;
    logic                     slot;
    logic [1:0]               pos;
    logic [7:0]               left;
    reg_bank_type             regs;
    logic [15:0]              rdata;
    logic [2:0]               led;
    logic                     floating;
    logic                     acc_clr;
    logic                     acc_en;
    logic                     acc_sub;
    logic [`ADC_W-1:0]        sample;
    logic [`ACC_W-1:0]        result;
    logic                     result_valid;
    logic [15:0]              fe_path;
    logic [1:0]               amp_ref;
    logic [1:0]               cathode_sel;
    logic                     cathode_ovr;
  } seq_regs_type;

  typedef struct packed
  {
    logic [`ACC_W-1:0] acc;
  } acc_regs_type;

endpackage : float_seq_pkg

// *** common/float_seq_regs.svh ***
`ifndef FLOAT_SEQ_REGS_SVH
`define FLOAT_SEQ_REGS_SVH

// register byte addresses
`define LED_SRC_SEL_ADDR    8'h14
`define A_FLOAT_CFG_ADDR    8'h3e
`define B_FLOAT_CFG_ADDR    8'h3f
`define A_AMP_REF_ADDR      8'h42
`define A_FE_PATH_ADDR      8'h43
`define B_AMP_REF_ADDR      8'h44
`define B_FE_PATH_ADDR      8'h45
`define CATHODE_CTRL_ADDR   8'h54
`define PAIR_MATH_ADDR      8'h58
`define B_FLOAT_EN_ADDR     8'h59
`define FIRE_MASK_ADDR      8'h5a
`define A_FLOAT_EN_ADDR     8'h5e

// storage index of each register
`define IDX_LED_SRC         4'h0
`define IDX_A_FLOAT_CFG     4'h1
`define IDX_B_FLOAT_CFG     4'h2
`define IDX_A_AMP_REF       4'h3
`define IDX_A_FE_PATH       4'h4
`define IDX_B_AMP_REF       4'h5
`define IDX_B_FE_PATH       4'h6
`define IDX_CATHODE         4'h7
`define IDX_PAIR_MATH       4'h8
`define IDX_B_FLOAT_EN      4'h9
`define IDX_FIRE_MASK       4'ha
`define IDX_A_FLOAT_EN      4'hb
`define IDX_NONE            4'hf
`define NUM_REGS            12

// field positions (slot b adds the stated step)
`define LED_SRC_LSB         0
`define LED_SRC_STEP        2
`define FLOAT_EN_LSB        13
`define FIRST_MATH_LSB      1
`define SECOND_MATH_LSB     8
`define MATH_SLOT_B_STEP    4
`define MATH_SLOT_B_STEP2   2
`define AMP_REF_LSB         4
`define CATHODE_SEL_LSB     8
`define CATHODE_SEL_STEP    2
`define CATHODE_OVR_BIT     7
`define FIRE_MASK_LSB       8
`define FIRE_MASK_STEP      4
`define FLOAT_CHOICE_LSB    14

// field values
`define FLOAT_SRC_VALUE     2'h0
`define FLOAT_EN_VALUE      2'h3

// widths and reset values
`define ADC_W               14
`define ACC_W               27
`define REG_RESET           16'h0000

`endif

// *** dv/float_frontend_model.sv ***
`timescale 1ns/1ps
`include "float_seq_regs.svh"

module float_frontend_model
#(
  parameter int AMBIENT  = 300,
  parameter int LED_GAIN = 1000
)
(
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // request and led drive from the device
  input  wire logic              start_i,
  input  wire logic [7:0]        count_i,
  input  wire logic [2:0]        led_fire_i,
  // timing core and converter
  output logic                   led_window_o,
  output logic                   connect_o,
  output logic                   pulse_done_o,
  output logic [`ADC_W-1:0]      adc_data_o
);
  int   n_left;
  logic lit;

  ////////////////////////////////////////////////////////////////////////////////
  // connect, float with led window, then one converter result per pulse
  initial
  begin
    led_window_o = 1'b0;
    connect_o    = 1'b1;
    pulse_done_o = 1'b0;
    adc_data_o   = '0;
    forever
    begin
      @(posedge mclk_i);
      if (resetn_i === 1'b1 && start_i === 1'b1)
      begin
        n_left = count_i;
        while (n_left > 0)
        begin
          lit = 1'b0;
          // same length for every pulse, first one included
          for (int k = 0; k < 8; k++)
          begin
            @(negedge mclk_i);
            connect_o    = (k < 2);
            led_window_o = (k >= 2 && k < 6);
            // led drive lags the window by a cycle, so look past it
            if (k >= 2 && led_fire_i !== 3'b000)
              lit = 1'b1;
          end
          @(negedge mclk_i);
          pulse_done_o = 1'b1;
          // charge holds ambient always, led light only if it fired
          adc_data_o   = `ADC_W'(AMBIENT + (lit ? LED_GAIN : 0));
          @(negedge mclk_i);
          pulse_done_o = 1'b0;
          adc_data_o   = ~adc_data_o; // stale data is not left on the bus
          n_left--;
        end
        connect_o = 1'b1;
      end
    end
  end
endmodule : float_frontend_model

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "float_seq_regs.svh"

module tb;
  import float_seq_pkg::*;
  localparam int AMB  = 300;
  localparam int GAIN = 1000;

  logic mclk_i, resetn_i, reg_we_i, reg_re_i, slot_start_i, slot_sel_i;
  logic led_window_i, connect_i, pulse_done_i, float_o, cathode_override_enable_o;
  logic result_valid_o;
  logic [7:0] reg_addr_i, pulse_count_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, front_end_path_o;
  logic [`ADC_W-1:0] adc_data_i;
  logic [2:0] led_fire_o;
  logic [1:0] amp_reference_select_o, cathode_bias_select_o;
  logic [`ACC_W-1:0] result_o;
  int errors, n_compared;

  float_led_pulse_sequencer uut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .slot_start_i(slot_start_i),
    .slot_sel_i(slot_sel_i), .pulse_count_i(pulse_count_i), .led_window_i(led_window_i),
    .connect_i(connect_i), .pulse_done_i(pulse_done_i), .adc_data_i(adc_data_i),
    .led_fire_o(led_fire_o), .float_o(float_o), .front_end_path_o(front_end_path_o),
    .amp_reference_select_o(amp_reference_select_o),
    .cathode_bias_select_o(cathode_bias_select_o),
    .cathode_override_enable_o(cathode_override_enable_o),
    .result_o(result_o), .result_valid_o(result_valid_o));

  float_frontend_model #(.AMBIENT(AMB), .LED_GAIN(GAIN)) fe (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .start_i(slot_start_i), .count_i(pulse_count_i),
    .led_fire_i(led_fire_o), .led_window_o(led_window_i), .connect_o(connect_i),
    .pulse_done_o(pulse_done_i), .adc_data_o(adc_data_i));

  ////////////////////////////////////////////////////////////////////////////////
  // compare tasks and closing
  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_res(input string what, input logic [`ACC_W-1:0] exp,
                         input logic [`ACC_W-1:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_res

  task automatic chk_ctl(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_ctl

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////////
  // register port: one strobe cycle, read data valid after the taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk_i);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_we_i    = 1'b1;
    @(negedge mclk_i);
    reg_we_i    = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_re_i   = 1'b1;
    @(negedge mclk_i);
    reg_re_i   = 1'b0;
    chk_reg("register read", exp, reg_rdata_o);
  endtask : rd

  // other slot gets the inverse so a swapped field shows up in the result
  task automatic cfg(input logic s, input logic [3:0] m, input logic [1:0] f, input logic [1:0] g,
                     input logic [1:0] c);
    wr(`FIRE_MASK_ADDR, s ? {m, ~m, 8'h00} : {~m, m, 8'h00});
    wr(`PAIR_MATH_ADDR, s ? {4'h0, g, ~g, 1'b0, f, 2'b00, ~f, 1'b0}
                          : {4'h0, ~g, g, 1'b0, ~f, 2'b00, f, 1'b0});
    wr(s ? `B_FLOAT_CFG_ADDR : `A_FLOAT_CFG_ADDR, {c, 14'h0000});
    wr(s ? `A_FLOAT_CFG_ADDR : `B_FLOAT_CFG_ADDR, {~c, 14'h0000});
  endtask : cfg

  // one sample period; expectation built pulse by pulse from mask and math
  task automatic run(input logic s, input logic [7:0] n, input logic [3:0] m,
                     input logic [1:0] f, input logic [1:0] g, input logic [1:0] c,
                     input logic taken);
    logic [`ACC_W-1:0] exp;
    logic [`ACC_W-1:0] got;
    logic [3:0]        n_valid;
    logic              prev_win;
    logic              prev_conn;
    logic [3:0]        exp_led;
    int                v;
    exp       = '0;
    got       = '0;
    n_valid   = '0;
    prev_win  = 1'b0;
    prev_conn = 1'b0;
    // refused samples must leave every led dark
    exp_led   = taken ? {1'b0, 3'b001 << (c - 2'b01)} : 4'h0;
    for (int i = 0; i < n; i++)
    begin
      v = AMB + ((m[i % 4] == 1'b0 && c != 2'b00) ? GAIN : 0);
      if ((i % 4 == 0 && f[1]) || (i % 4 == 1 && f[0]) || (i % 4 == 2 && g[1])
          || (i % 4 == 3 && g[0]))
        exp = exp - `ACC_W'(v);
      else
        exp = exp + `ACC_W'(v);
    end
    @(negedge mclk_i);
    slot_sel_i    = s;
    pulse_count_i = n;
    slot_start_i  = 1'b1;
    @(negedge mclk_i);
    slot_start_i  = 1'b0;
    for (int k = 0; k < 16 * n + 40; k++)
    begin
      @(negedge mclk_i);
      // the model moves its pins on this same edge, so read them once settled
      #1;
      if (result_valid_o === 1'b1)
      begin
        n_valid++;
        got = result_o;
      end
      if (prev_win && led_window_i === 1'b1)
        chk_ctl("float level", {3'b000, taken}, {3'b000, float_o});
      if (prev_conn)
        chk_ctl("float in dump", 4'h0, {3'b000, float_o});
      if (led_fire_o !== 3'b000 || !taken)
        chk_ctl("led select", exp_led, {1'b0, led_fire_o});
      prev_win  = led_window_i;
      prev_conn = connect_i;
    end
    chk_ctl("result writes", {3'b000, taken}, n_valid);
    if (taken)
      chk_res("result", exp, got);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    logic [7:0] a [12];
    a = '{`LED_SRC_SEL_ADDR, `A_FLOAT_CFG_ADDR, `B_FLOAT_CFG_ADDR, `A_AMP_REF_ADDR,
          `A_FE_PATH_ADDR, `B_AMP_REF_ADDR, `B_FE_PATH_ADDR, `CATHODE_CTRL_ADDR,
          `PAIR_MATH_ADDR, `B_FLOAT_EN_ADDR, `FIRE_MASK_ADDR, `A_FLOAT_EN_ADDR};
    foreach (a[i])
      rd(a[i], `REG_RESET);
    foreach (a[i])
      wr(a[i], {a[i], ~a[i]});
    wr(8'h20, 16'hffff);
    foreach (a[i])
      rd(a[i], {a[i], ~a[i]});
    rd(8'h20, 16'h0000);
  endtask : t_regs

  task automatic t_base;
    wr(`LED_SRC_SEL_ADDR, 16'h0000);
    wr(`A_FLOAT_EN_ADDR, 16'h6000);
    wr(`B_FLOAT_EN_ADDR, 16'h6000);
    wr(`A_FE_PATH_ADDR, 16'hae65);
    wr(`B_FE_PATH_ADDR, 16'h1234);
    wr(`A_AMP_REF_ADDR, 16'h0020);
    wr(`B_AMP_REF_ADDR, 16'h0010);
    wr(`CATHODE_CTRL_ADDR, 16'h0680);
  endtask : t_base

  task automatic t_analog(input logic [15:0] p, input logic [1:0] r, input logic [1:0] k);
    chk_reg("path", p, front_end_path_o);
    chk_ctl("amp ref", {2'b00, r}, {2'b00, amp_reference_select_o});
    chk_ctl("cathode", {2'b00, k}, {2'b00, cathode_bias_select_o});
    chk_ctl("override", 4'h1, {3'b000, cathode_override_enable_o});
  endtask : t_analog

  task automatic t_flow;
    // recommended group, 32 pulses, eight repeats and one write
    cfg(1'b1, 4'h9, 2'd2, 2'd1, 2'b01);
    run(1'b1, 8'd32, 4'h9, 2'd2, 2'd1, 2'b01, 1'b1);
    t_analog(16'h1234, 2'd1, 2'd1);
    cfg(1'b0, 4'h5, 2'd3, 2'd3, 2'b10);
    run(1'b0, 8'd8, 4'h5, 2'd3, 2'd3, 2'b10, 1'b1);
    t_analog(16'hae65, 2'd2, 2'd2);
    cfg(1'b0, 4'h9, 2'd1, 2'd0, 2'b00);
    run(1'b0, 8'd2, 4'h9, 2'd1, 2'd0, 2'b00, 1'b1);
    // slot a source not float: refused, slot b still runs
    wr(`LED_SRC_SEL_ADDR, 16'h0001);
    run(1'b0, 8'd4, 4'h9, 2'd1, 2'd0, 2'b00, 1'b0);
    cfg(1'b1, 4'h6, 2'd0, 2'd2, 2'b11);
    run(1'b1, 8'd4, 4'h6, 2'd0, 2'd2, 2'b11, 1'b1);
    wr(`LED_SRC_SEL_ADDR, 16'h0000);
    run(1'b1, 8'd0, 4'h6, 2'd0, 2'd2, 2'b11, 1'b0);
    wr(`B_FLOAT_EN_ADDR, 16'h4000);
    run(1'b1, 8'd4, 4'h6, 2'd0, 2'd2, 2'b11, 1'b0);
  endtask : t_flow

  // reset in the middle of a sample: outputs and registers clear, no write follows
  task automatic t_reset;
    int n_valid;
    n_valid = 0;
    @(negedge mclk_i);
    slot_sel_i    = 1'b0;
    pulse_count_i = 8'd8;
    slot_start_i  = 1'b1;
    @(negedge mclk_i);
    slot_start_i  = 1'b0;
    repeat (25) @(negedge mclk_i);
    resetn_i = 1'b0;
    @(negedge mclk_i);
    chk_res("reset result", '0, result_o);
    chk_ctl("reset float and led", 4'h0, {float_o, led_fire_o});
    chk_reg("reset path", 16'h0000, front_end_path_o);
    chk_ctl("reset analog", 4'h0, {amp_reference_select_o, cathode_bias_select_o});
    chk_ctl("reset override", 4'h0, {2'b00, cathode_override_enable_o, result_valid_o});
    @(negedge mclk_i);
    resetn_i = 1'b1;
    // the model finishes its pulses; an idle sequencer must ignore them
    for (int k = 0; k < 120; k++)
    begin
      @(negedge mclk_i);
      if (result_valid_o === 1'b1)
        n_valid++;
    end
    chk_ctl("writes after reset", 4'h0, 4'(n_valid));
    rd(`A_FLOAT_EN_ADDR, `REG_RESET);
  endtask : t_reset

  ////////////////////////////////////////////////////////////////////////////////
  // clock, reset, sequence and watchdog
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial
  begin
    {resetn_i, reg_we_i, reg_re_i, slot_start_i, slot_sel_i} = '0;
    reg_addr_i    = '0;
    reg_wdata_i   = '0;
    pulse_count_i = '0;
    errors        = 0;
    n_compared    = 0;
    repeat (16) @(negedge mclk_i);
    resetn_i = 1'b1;
    t_regs();
    t_base();
    t_flow();
    t_reset();
    report_and_stop();
  end

  // whole run is under two thousand cycles; this limit is far past it
  initial
  begin
    #500_000;
    errors++;
    report_and_stop();
  end
endmodule : tb

// *** verilog/float_accumulator.sv ***
`timescale 1ns/1ps
`include "float_seq_regs.svh"

module float_accumulator
  import float_seq_pkg::*;
(
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                resetn_i,
  // control
  input  wire logic                clr_i,
  input  wire logic                en_i,
  input  wire logic                sub_i,
  input  wire logic [`ADC_W-1:0]   sample_i,
  // result
  output logic      [`ACC_W-1:0]   acc_o
);

  acc_regs_type st_r;
  acc_regs_type st_nxt;
  logic [`ACC_W-1:0] ext;

  // samples are signed, so widen by sign extension
  always_comb
  begin
    st_nxt = st_r;
    ext    = {{(`ACC_W-`ADC_W){sample_i[`ADC_W-1]}}, sample_i};
    if (clr_i)
    begin
      st_nxt.acc = '0;
    end
    else if (en_i)
    begin
      st_nxt.acc = sub_i ? st_r.acc - ext : st_r.acc + ext;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign acc_o = st_r.acc;

endmodule : float_accumulator

// *** verilog/float_led_pulse_sequencer.sv ***
`timescale 1ns/1ps
`include "float_seq_regs.svh"

module float_led_pulse_sequencer
  import float_seq_pkg::*;
(
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                resetn_i,
  // register port
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [15:0]         reg_wdata_i,
  input  wire logic                reg_we_i,
  input  wire logic                reg_re_i,
  output logic      [15:0]         reg_rdata_o,
  // timing core
  input  wire logic                slot_start_i,
  input  wire logic                slot_sel_i,
  input  wire logic [7:0]          pulse_count_i,
  input  wire logic                led_window_i,
  input  wire logic                connect_i,
  // converter
  input  wire logic                pulse_done_i,
  input  wire logic [`ADC_W-1:0]   adc_data_i,
  // led and analog controls
  output logic      [2:0]          led_fire_o,
  output logic                     float_o,
  output logic      [15:0]         front_end_path_o,
  output logic      [1:0]          amp_reference_select_o,
  output logic      [1:0]          cathode_bias_select_o,
  output logic                     cathode_override_enable_o,
  // result write
  output logic      [`ACC_W-1:0]   result_o,
  output logic                     result_valid_o
);

  seq_regs_type      st_r;
  seq_regs_type      st_nxt;
  logic [`ACC_W-1:0] acc;
  logic              mode_ok;
  logic              fire_now;
  logic              sub_now;
  logic [1:0]        choice;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] addr_index(input logic [7:0] a);
    case (a)
      `LED_SRC_SEL_ADDR:  addr_index = `IDX_LED_SRC;
      `A_FLOAT_CFG_ADDR:  addr_index = `IDX_A_FLOAT_CFG;
      `B_FLOAT_CFG_ADDR:  addr_index = `IDX_B_FLOAT_CFG;
      `A_AMP_REF_ADDR:    addr_index = `IDX_A_AMP_REF;
      `A_FE_PATH_ADDR:    addr_index = `IDX_A_FE_PATH;
      `B_AMP_REF_ADDR:    addr_index = `IDX_B_AMP_REF;
      `B_FE_PATH_ADDR:    addr_index = `IDX_B_FE_PATH;
      `CATHODE_CTRL_ADDR: addr_index = `IDX_CATHODE;
      `PAIR_MATH_ADDR:    addr_index = `IDX_PAIR_MATH;
      `B_FLOAT_EN_ADDR:   addr_index = `IDX_B_FLOAT_EN;
      `FIRE_MASK_ADDR:    addr_index = `IDX_FIRE_MASK;
      `A_FLOAT_EN_ADDR:   addr_index = `IDX_A_FLOAT_EN;
      default:            addr_index = `IDX_NONE;
    endcase
  endfunction : addr_index

  // two-bit field of a register, shifted by a per-slot step
  function automatic logic [1:0] field2(input logic [15:0] v, input int lsb);
    field2 = v[lsb +: 2];
  endfunction : field2

  // pair math: bit1 set subtracts earlier pulse, bit0 set subtracts later one
  function automatic logic pos_subtract(input logic [15:0] m, input logic s,
                                        input logic [1:0] p);
    logic [1:0] f;
    if (p[1])
      f = field2(m, s ? `SECOND_MATH_LSB + `MATH_SLOT_B_STEP2 : `SECOND_MATH_LSB);
    else
      f = field2(m, s ? `FIRST_MATH_LSB + `MATH_SLOT_B_STEP : `FIRST_MATH_LSB);
    pos_subtract = p[0] ? f[0] : f[1];
  endfunction : pos_subtract

  ////////////////////////////////////////////////////////////////////////////
  // per-slot decode of the active configuration

  always_comb
  begin
    mode_ok =
      (field2(st_r.regs[`IDX_LED_SRC], slot_sel_i ? `LED_SRC_STEP : `LED_SRC_LSB)
        == `FLOAT_SRC_VALUE) &&
      (field2(st_r.regs[slot_sel_i ? `IDX_B_FLOAT_EN : `IDX_A_FLOAT_EN],
        `FLOAT_EN_LSB) == `FLOAT_EN_VALUE);
    // mask is active low, pulse one in the lowest bit
    fire_now = !st_r.regs[`IDX_FIRE_MASK][`FIRE_MASK_LSB
                 + (st_r.slot ? `FIRE_MASK_STEP : 0) + st_r.pos];
    sub_now  = pos_subtract(st_r.regs[`IDX_PAIR_MATH], st_r.slot, st_r.pos);
    choice   = field2(st_r.regs[st_r.slot ? `IDX_B_FLOAT_CFG : `IDX_A_FLOAT_CFG],
                      `FLOAT_CHOICE_LSB);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt              = st_r;
    st_nxt.acc_clr      = 1'b0;
    st_nxt.acc_en       = 1'b0;
    st_nxt.result_valid = 1'b0;
    st_nxt.led          = 3'b000;

    // register writes; unmapped addresses are ignored
    if (reg_we_i && addr_index(reg_addr_i) != `IDX_NONE)
    begin
      st_nxt.regs[addr_index(reg_addr_i)] = reg_wdata_i;
    end
    // unmapped reads return zero
    if (reg_re_i)
    begin
      st_nxt.rdata = (addr_index(reg_addr_i) == `IDX_NONE) ? 16'h0000
                   : st_r.regs[addr_index(reg_addr_i)];
    end

    case (st_r.fsm)
      IDLE_S:
      begin
        // a zero pulse count would wrap and run 256 pulses, so such a start is dropped
        if (slot_start_i && mode_ok && pulse_count_i != 8'h00)
        begin
          st_nxt.fsm     = RUN_S;
          st_nxt.slot    = slot_sel_i;
          st_nxt.pos     = 2'b00;
          st_nxt.left    = pulse_count_i;
          st_nxt.acc_clr = 1'b1;
        end
      end
      RUN_S:
      begin
        // led only lights in positions the mask selects
        if (led_window_i && fire_now)
        begin
          st_nxt.led = {choice == 2'h3, choice == 2'h2, choice == 2'h1};
        end
        if (pulse_done_i)
        begin
          st_nxt.acc_en  = 1'b1;
          st_nxt.acc_sub = sub_now;
          st_nxt.sample  = adc_data_i;
          st_nxt.pos     = st_r.pos + 2'b01;
          st_nxt.left    = st_r.left - 8'h01;
          if (st_r.left == 8'h01)
          begin
            st_nxt.fsm = DRAIN_S;
          end
        end
      end
      // one cycle for the last sample to reach the accumulator
      DRAIN_S:
      begin
        st_nxt.fsm = WRITE_S;
      end
      WRITE_S:
      begin
        st_nxt.result       = acc;
        st_nxt.result_valid = 1'b1;
        st_nxt.fsm          = IDLE_S;
      end
      default:
      begin
        st_nxt.fsm = IDLE_S;
      end
    endcase

    // photodiode floats whenever the sequence runs and no charge dump is on
    st_nxt.floating = (st_nxt.fsm == RUN_S) && !connect_i;

    // analog settings of the slot last started, plus the shared override, re-read from the registers every cycle
    st_nxt.fe_path     = st_r.regs[st_r.slot ? `IDX_B_FE_PATH : `IDX_A_FE_PATH];
    st_nxt.amp_ref     = field2(st_r.regs[st_r.slot ? `IDX_B_AMP_REF : `IDX_A_AMP_REF],
                                `AMP_REF_LSB);
    st_nxt.cathode_sel = field2(st_r.regs[`IDX_CATHODE], st_r.slot
                           ? `CATHODE_SEL_LSB + `CATHODE_SEL_STEP
                           : `CATHODE_SEL_LSB);
    st_nxt.cathode_ovr = st_r.regs[`IDX_CATHODE][`CATHODE_OVR_BIT];
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r      <= '0;
      st_r.regs <= {`NUM_REGS{`REG_RESET}};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  float_accumulator u_acc
  (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .clr_i    (st_r.acc_clr),
    .en_i     (st_r.acc_en),
    .sub_i    (st_r.acc_sub),
    .sample_i (st_r.sample),
    .acc_o    (acc)
  );

  // outputs straight from the state flops
  assign reg_rdata_o               = st_r.rdata;
  assign led_fire_o                = st_r.led;
  assign float_o                   = st_r.floating;
  assign front_end_path_o          = st_r.fe_path;
  assign amp_reference_select_o    = st_r.amp_ref;
  assign cathode_bias_select_o     = st_r.cathode_sel;
  assign cathode_override_enable_o = st_r.cathode_ovr;
  assign result_o                  = st_r.result;
  assign result_valid_o            = st_r.result_valid;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence last_pulse_s;
    st_r.fsm == RUN_S && pulse_done_i && st_r.left == 8'h01;
  endsequence

  sequence single_write_s;
    !result_valid_o ##1 !result_valid_o ##1 result_valid_o ##1 !result_valid_o;
  endsequence

  one_write_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    last_pulse_s |=> single_write_s)
    else $error("result not written once after last pulse");

  lit_pos_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r.fsm == RUN_S && led_window_i && fire_now && choice == 2'h1)
      |=> led_fire_o == 3'b001)
    else $error("led1 not fired in a selected position");

  dark_pos_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r.fsm == RUN_S && !fire_now) |=> led_fire_o == 3'b000)
    else $error("led fired in a masked position");

  pulse_sign_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r.fsm == RUN_S && pulse_done_i)
      |=> st_r.acc_en && st_r.acc_sub == $past(sub_now))
    else $error("accumulate sign does not follow pair math");

  pos_wrap_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r.fsm == RUN_S && pulse_done_i)
      |=> st_r.pos == $past(st_r.pos) + 2'b01)
    else $error("pulse position did not advance");

  mode_gate_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    (st_r.fsm == IDLE_S && slot_start_i && !mode_ok) |=> st_r.fsm == IDLE_S)
    else $error("sequence started outside float mode");

  float_conn_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    float_o |-> $past(connect_i) == 1'b0 && st_r.fsm == RUN_S)
    else $error("photodiode floated during a charge dump");

  path_out_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    ##1 front_end_path_o == $past(st_r.regs[st_r.slot ? `IDX_B_FE_PATH : `IDX_A_FE_PATH]))
    else $error("front end path not taken from slot register");

  override_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    ##1 cathode_override_enable_o == $past(st_r.regs[`IDX_CATHODE][`CATHODE_OVR_BIT]))
    else $error("cathode override does not follow its bit");

  // recommended pair math, read straight from the fields: outer pulses subtract
  sequence rec_math_pulse_s;
    st_r.fsm == RUN_S && pulse_done_i
      && st_r.regs[`IDX_PAIR_MATH][(st_r.slot ? `FIRST_MATH_LSB + `MATH_SLOT_B_STEP
                                              : `FIRST_MATH_LSB) +: 2] == 2'h2
      && st_r.regs[`IDX_PAIR_MATH][(st_r.slot ? `SECOND_MATH_LSB + `MATH_SLOT_B_STEP2
                                              : `SECOND_MATH_LSB) +: 2] == 2'h1;
  endsequence

  rec_sign_a: assert property (
    @(posedge mclk_i) disable iff (!resetn_i)
    rec_math_pulse_s
      |=> st_r.acc_sub == ($past(st_r.pos) == 2'b00 || $past(st_r.pos) == 2'b11))
    else $error("recommended group not added and subtracted as set");

endmodule : float_led_pulse_sequencer
